// ===== common/bsdc_map.svh
// Purpose: command codes, field positions, reset values and counts of the
//          bridge serial diagnosis and control block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef BSDC_MAP_SVH
`define BSDC_MAP_SVH

// command codes, top three bits of the command byte
`define BSDC_CMD_READ_FAULT 3'h0
`define BSDC_CMD_READ_VERSION 3'h1
`define BSDC_CMD_READ_SETUP 3'h3
`define BSDC_CMD_CLEAR_FAULT 3'h4
`define BSDC_CMD_WRITE_SETUP_READ_FAULT 3'h6
`define BSDC_CMD_WRITE_SETUP 3'h7

// bridge_setup_word fields
`define BSDC_SETUP_LOAD_PROBE_OFF 4
`define BSDC_SETUP_SERIAL_DRIVE_SELECT 3
`define BSDC_SETUP_SOFT_OUTPUT_ON 2
`define BSDC_SETUP_SOFT_HEADING 1
`define BSDC_SETUP_SOFT_CHOP_LEVEL 0
`define BSDC_SETUP_RESET 8'h00

// fault_report_word fields
`define BSDC_FAULT_ENABLED 7
`define BSDC_FAULT_OVERHEAT 6
`define BSDC_FAULT_TX_CHECK 5
`define BSDC_FAULT_CURRENT_LIMIT 4
`define BSDC_FAULT_RESET 8'hdf

// fault code nibble
`define BSDC_CODE_NONE 4'hf
`define BSDC_CODE_OPEN 4'hc
`define BSDC_CODE_SUPPLY_LOW 4'h3

// version word: fixed upper nibble
`define BSDC_VERSION_HIGH 4'h2

// on-state open-load pulse count
`define BSDC_OPEN_COUNT 3'h5

`endif

// ===== common/bsdc_pkg.sv
// Purpose: types of the bridge serial diagnosis and control block
// Assumes: nothing
// Notes:   constants live in bsdc_map.svh
package bsdc_pkg;

    typedef enum logic [1:0] {
        BSDC_RESP_FAULT = 2'b00,
        BSDC_RESP_SETUP = 2'b01,
        BSDC_RESP_VERSION = 2'b10
    } bsdc_resp_t;

    typedef struct packed {
        logic [7:0] setup;
        bsdc_resp_t resp;
        logic in_frame;
        logic seen_rise;
        logic [7:0] shift_out;
        logic [7:0] shift_in;
        logic sclk_q;
        logic sel_q;
        logic off_q;
        logic pwm_q;
        logic dir_q;
        logic en_q;
        logic olp_q;
        logic fw_q;
        logic ground_short_a;
        logic battery_short_a;
        logic ground_short_b;
        logic battery_short_b;
        logic current_limit_flag;
        logic open_on;
        logic [2:0] open_cnt;
        logic [2:0] fw_cnt;
        logic sdo;
        logic sdo_oe_n;
        logic drv_en;
        logic drv_dir;
        logic drv_pwm;
        logic probe_on;
        logic fault_beacon;
    } bsdc_state_t;

endpackage

// ===== design/bsdc_sync.sv
// Purpose: two-stage synchroniser for a group of outside levels
// Assumes: inputs asynchronous to clk_sys_in
// Notes:   only the second stage leaves this module
module bsdc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bsdc_sync_t;

    bsdc_sync_t s;
    bsdc_sync_t next_s;

    always_comb begin
        next_s.s1 = d_in;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= {RST_VAL, RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign q_out = s.s2;
endmodule // bsdc_sync

// ===== design/bsdc_fault_enc.sv
// Purpose: fault code nibble from short, open and supply flags
// Assumes: flags already latched as wanted by the caller
// Notes:   combinational; only valid codes can leave
`include "bsdc_map.svh"

module bsdc_fault_enc (
    input wire logic ground_short_a_in,
    input wire logic battery_short_a_in,
    input wire logic ground_short_b_in,
    input wire logic battery_short_b_in,
    input wire logic open_circuit_fault_in,
    input wire logic supply_low_in,
    output logic [3:0] code_out
);
    logic bat_a;
    logic bat_b;

    // both shorts on one output would alias another code; ground wins
    assign bat_a = battery_short_a_in & ~ground_short_a_in;
    assign bat_b = battery_short_b_in & ~ground_short_b_in;

    always_comb begin
        if (supply_low_in) begin
            code_out = `BSDC_CODE_SUPPLY_LOW;
        end else if (ground_short_a_in | bat_a | ground_short_b_in |
                     bat_b) begin
            code_out = ~{bat_b, ground_short_b_in, bat_a,
                         ground_short_a_in};
        end else if (open_circuit_fault_in) begin
            code_out = `BSDC_CODE_OPEN;
        end else begin
            code_out = `BSDC_CODE_NONE;
        end
    end
endmodule // bsdc_fault_enc

// ===== design/bsdc_top.sv
// Purpose: serial command, diagnosis and control slave of a bridge driver
// Assumes: link pins and analog flags are asynchronous; all are synced
// Notes:   link edges are found by sampling on clk_sys_in
//
// What this block does
// - flag driven on output before first rise
// - flag high whenever outputs are tristated
// - flag ORed with serial input for chaining
// - decode reads by top three bits
// - clear command clears faults, answers fault word
// - write setup, answer setup word
// - write setup, answer fault word
// - first answer after reset is version
// - unknown command answers fault word
// - probe off disconnects sources, hides open load
// - serial select accepted only with pins low
// - any pin change drops serial select
// - soft output on enables under serial select
// - soft heading and chop replace pins
// - fault bit 7 shows pin enable
// - overheat and current limit bits active low
// - fault bit 5 always zero
// - encode short codes in low nibble
// - off-state open and supply low unlatched, shorts latched
// - fault word cleared on listed events
// - dir pin change clears limit and open flags
// - five freewheel pulses clear open flag
// - eight bits MSB first, sample fall
// - each select low pulse is one frame
`include "bsdc_map.svh"

module bsdc_top
    import bsdc_pkg::*;
#(
    parameter logic [3:0] VERSION = 4'h1 // arbitrary value
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic select_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    input wire logic bridge_off_pin_in,
    input wire logic pwm_in,
    input wire logic dir_in,
    input wire logic overheat_flag_in,
    input wire logic current_limit_flag_in,
    input wire logic ground_short_a_in,
    input wire logic battery_short_a_in,
    input wire logic ground_short_b_in,
    input wire logic battery_short_b_in,
    input wire logic open_off_in,
    input wire logic open_pulse_in,
    input wire logic freewheel_pulse_in,
    input wire logic supply_low_in,
    input wire logic sleep_in,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    output logic bridge_enable_out,
    output logic bridge_dir_out,
    output logic bridge_pwm_out,
    output logic load_probe_on_out,
    output logic fault_beacon_out
);

    ////////////////////////////////////////////////////////////////////
    // input synchronisers

    localparam int NSYNC = 17;
    logic [NSYNC-1:0] sync_q;
    logic sel_s;
    logic sclk_s;
    logic sdi_s;
    logic off_s;
    logic pwm_s;
    logic dir_s;
    logic ot_s;
    logic cl_s;
    logic ga_s;
    logic ba_s;
    logic gb_s;
    logic bb_s;
    logic olo_s;
    logic olp_s;
    logic fw_s;
    logic uv_s;
    logic sleep_s;

    // select idles high so reset does not fake a frame start
    bsdc_sync #(
        .W(NSYNC),
        .RST_VAL(17'h10000)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .d_in({select_n_in, sclk_in, sdi_in, bridge_off_pin_in, pwm_in,
               dir_in, overheat_flag_in, current_limit_flag_in,
               ground_short_a_in, battery_short_a_in, ground_short_b_in,
               battery_short_b_in, open_off_in, open_pulse_in,
               freewheel_pulse_in, supply_low_in, sleep_in}),
        .q_out(sync_q)
    );

    assign {sel_s, sclk_s, sdi_s, off_s, pwm_s, dir_s, ot_s, cl_s, ga_s,
            ba_s, gb_s, bb_s, olo_s, olp_s, fw_s, uv_s, sleep_s} = sync_q;

    ////////////////////////////////////////////////////////////////////
    // events and derived levels

    bsdc_state_t s;
    bsdc_state_t next_s;

    logic sel_fall;
    logic sel_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic pin_change;
    logic dir_change;
    logic eff_en;
    logic en_toggle;
    logic cmd_clear;
    logic diag_clear;
    logic open_report;
    logic [3:0] code;
    logic [7:0] fault_word;
    logic [7:0] version_word;
    logic [2:0] cmd;
    logic pins_low;

    assign sel_fall = s.sel_q & ~sel_s;
    assign sel_rise = ~s.sel_q & sel_s;
    assign sclk_rise = ~s.sclk_q & sclk_s;
    assign sclk_fall = s.sclk_q & ~sclk_s;
    assign dir_change = s.dir_q ^ dir_s;
    assign pin_change = (s.off_q ^ off_s) | (s.pwm_q ^ pwm_s) | dir_change;
    assign pins_low = ~off_s & ~pwm_s & ~dir_s;
    assign cmd = s.shift_in[7:5];

    assign eff_en = s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT] ?
                    s.setup[`BSDC_SETUP_SOFT_OUTPUT_ON] : ~off_s;
    assign en_toggle = eff_en ^ s.en_q;
    assign cmd_clear = sel_rise & s.in_frame &
                       (cmd == `BSDC_CMD_CLEAR_FAULT);
    assign diag_clear = uv_s | sleep_s | en_toggle | cmd_clear;

    assign open_report = ~s.setup[`BSDC_SETUP_LOAD_PROBE_OFF] &
                         (s.open_on | (~eff_en & olo_s));

    bsdc_fault_enc u_enc (
        .ground_short_a_in(s.ground_short_a),
        .battery_short_a_in(s.battery_short_a),
        .ground_short_b_in(s.ground_short_b),
        .battery_short_b_in(s.battery_short_b),
        .open_circuit_fault_in(open_report),
        .supply_low_in(uv_s),
        .code_out(code)
    );

    assign fault_word = {~off_s, ~ot_s, 1'b0, ~s.current_limit_flag, code};
    assign version_word = {`BSDC_VERSION_HIGH, VERSION};

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_s = s;
        next_s.sel_q = sel_s;
        next_s.sclk_q = sclk_s;
        next_s.off_q = off_s;
        next_s.pwm_q = pwm_s;
        next_s.dir_q = dir_s;
        next_s.en_q = eff_en;
        next_s.olp_q = olp_s;
        next_s.fw_q = fw_s;

        // shorts latch, a new short beats a clear
        next_s.ground_short_a = ga_s | (s.ground_short_a & ~diag_clear);
        next_s.battery_short_a = ba_s | (s.battery_short_a & ~diag_clear);
        next_s.ground_short_b = gb_s | (s.ground_short_b & ~diag_clear);
        next_s.battery_short_b = bb_s | (s.battery_short_b & ~diag_clear);

        next_s.current_limit_flag = cl_s |
            (s.current_limit_flag & ~dir_change & ~diag_clear);

        // dir pin change clears open, a same-cycle pulse wins
        if (dir_change | diag_clear) begin
            next_s.open_on = 1'b0;
            next_s.open_cnt = 3'h0;
            next_s.fw_cnt = 3'h0;
        end
        // on-state open load needs five pulses without freewheeling
        if (olp_s & ~s.olp_q) begin
            next_s.fw_cnt = 3'h0;
            if (s.open_cnt != `BSDC_OPEN_COUNT) begin
                next_s.open_cnt = s.open_cnt + 3'h1;
            end
            if (s.open_cnt + 3'h1 >= `BSDC_OPEN_COUNT) begin
                next_s.open_on = 1'b1;
            end
        end else if (fw_s & ~s.fw_q) begin
            next_s.open_cnt = 3'h0;
            if (s.fw_cnt != `BSDC_OPEN_COUNT) begin
                next_s.fw_cnt = s.fw_cnt + 3'h1;
            end
            if (s.fw_cnt + 3'h1 >= `BSDC_OPEN_COUNT) begin
                next_s.open_on = 1'b0;
            end
        end
        if (sel_fall) begin
            next_s.in_frame = 1'b1;
            next_s.seen_rise = 1'b0;
            case (s.resp)
                BSDC_RESP_SETUP: next_s.shift_out = s.setup;
                BSDC_RESP_VERSION: next_s.shift_out = version_word;
                default: next_s.shift_out = fault_word;
            endcase
        end else if (s.in_frame) begin
            if (sclk_rise) begin
                next_s.seen_rise = 1'b1;
                next_s.sdo = s.shift_out[7];
                next_s.shift_out = {s.shift_out[6:0], 1'b0};
            end
            if (sclk_fall) begin
                next_s.shift_in = {s.shift_in[6:0], sdi_s};
            end
            if (sel_rise) begin
                next_s.in_frame = 1'b0;
                case (cmd)
                    `BSDC_CMD_READ_FAULT: next_s.resp = BSDC_RESP_FAULT;
                    `BSDC_CMD_READ_VERSION: next_s.resp = BSDC_RESP_VERSION;
                    `BSDC_CMD_READ_SETUP: next_s.resp = BSDC_RESP_SETUP;
                    `BSDC_CMD_CLEAR_FAULT: next_s.resp = BSDC_RESP_FAULT;
                    `BSDC_CMD_WRITE_SETUP: begin
                        next_s.resp = BSDC_RESP_SETUP;
                        next_s.setup = s.shift_in;
                    end
                    `BSDC_CMD_WRITE_SETUP_READ_FAULT: begin
                        next_s.resp = BSDC_RESP_FAULT;
                        next_s.setup = s.shift_in;
                    end
                    default: next_s.resp = BSDC_RESP_FAULT;
                endcase
                if (!pins_low) begin
                    next_s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT] =
                        s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT];
                end
            end
        end

        if (pin_change) begin
            next_s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT] = 1'b0;
        end

        if (next_s.in_frame & ~next_s.seen_rise) begin
            next_s.sdo = s.fault_beacon | sdi_s;
        end
        next_s.sdo_oe_n = ~next_s.in_frame;
        if (!next_s.in_frame) begin
            next_s.sdo = 1'b0;
        end

        next_s.drv_dir = s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT] ?
                         s.setup[`BSDC_SETUP_SOFT_HEADING] : dir_s;
        next_s.drv_pwm = s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT] ?
                         s.setup[`BSDC_SETUP_SOFT_CHOP_LEVEL] : pwm_s;
        next_s.drv_en = eff_en & ~ot_s & ~uv_s & ~s.ground_short_a &
                        ~s.battery_short_a & ~s.ground_short_b &
                        ~s.battery_short_b;
        next_s.fault_beacon = ~next_s.drv_en;
        next_s.probe_on = ~eff_en & ~s.setup[`BSDC_SETUP_LOAD_PROBE_OFF];
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
            s.setup <= `BSDC_SETUP_RESET;
            s.resp <= BSDC_RESP_VERSION;
            s.sel_q <= 1'b1;
            s.sdo_oe_n <= 1'b1;
            s.en_q <= 1'b1;
            s.fault_beacon <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sdo_out = s.sdo;
    assign sdo_oe_n_out = s.sdo_oe_n;
    assign bridge_enable_out = s.drv_en;
    assign bridge_dir_out = s.drv_dir;
    assign bridge_pwm_out = s.drv_pwm;
    assign load_probe_on_out = s.probe_on;
    assign fault_beacon_out = s.fault_beacon;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    AST_FLAG_EARLY: assert property (
        (next_s.in_frame && !next_s.seen_rise) |=>
            (sdo_out == $past(s.fault_beacon | sdi_s)) && !sdo_oe_n_out)
        else $error("flag not on output before first rise");

    AST_BEACON_SHUT: assert property (
        (ot_s || uv_s || !eff_en) |=> fault_beacon_out)
        else $error("flag low while outputs shut");

    AST_READ_SETUP: assert property (
        (sel_rise && s.in_frame && cmd == `BSDC_CMD_READ_SETUP) |=>
            s.resp == BSDC_RESP_SETUP)
        else $error("setup read not decoded");

    AST_UNKNOWN_FAULT: assert property (
        (sel_rise && s.in_frame && cmd == 3'h2) |=>
            s.resp == BSDC_RESP_FAULT)
        else $error("unknown command not answered with fault word");

    AST_SELECT_GUARD: assert property (
        (sel_rise && s.in_frame && cmd[2:1] == 2'b11 && !pins_low &&
         !s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT]) |=>
            !s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT])
        else $error("serial select taken with pins active");

    AST_PIN_DROP: assert property (
        pin_change |=> !s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT])
        else $error("serial select kept after pin change");

    AST_SOFT_HEADING: assert property (
        s.setup[`BSDC_SETUP_SERIAL_DRIVE_SELECT] |=>
            bridge_dir_out == $past(s.setup[`BSDC_SETUP_SOFT_HEADING]))
        else $error("heading not from setup word");

    AST_CHECK_BIT: assert property (
        (sel_fall && s.resp == BSDC_RESP_FAULT) |=> !s.shift_out[5])
        else $error("check bit not zero");

    AST_SHORT_LATCH: assert property (
        (ga_s && !sleep_s) |=> s.ground_short_a && code[0] == 1'b0 ||
            uv_s)
        else $error("short not latched");

endmodule // bsdc_top

// ===== dv/bsdc_host.sv
// Purpose: host model driving frames into the bridge serial slave
// Assumes: sdo settles within 4 system clocks of a serial clock rise
// Notes:   serial clock stands low outside frames; 80 ns period
module bsdc_host (
    input wire logic clk_sys_in,
    input wire logic sdo_in,
    output logic select_n_out,
    output logic sclk_out,
    output logic sdi_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] resp;
    logic flag;

    initial begin
        select_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end

    // half a serial period, 40 ns
    task automatic half();
        repeat (8) @(posedge clk_sys_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one eight bit frame
    task automatic frame(input logic [7:0] cmd, input logic lead);
        select_n_out <= 1'b0;
        sdi_out <= lead;
        half();
        flag = sdo_in;
        for (int i = 7; i >= 0; i--) begin
            sclk_out <= 1'b1;
            sdi_out <= cmd[i];
            half();
            // sampled late in the high phase, long after the slave moved
            resp[i] = sdo_in;
            sclk_out <= 1'b0;
            half();
        end
        select_n_out <= 1'b1;
        // released data line must not look like a held bit
        sdi_out <= ~cmd[0];
        repeat (12) @(posedge clk_sys_in);
    endtask
endmodule // bsdc_host

// ===== dv/testbench.sv
// Purpose: self-checking bench of the bridge serial slave
// Assumes: answers of frame n show in frame n+1, captured at select fall
// Notes:   analog flags are pulsed by the bench; waits are fixed counts
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] VER = 4'ha; // arbitrary value
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic off = 1'b0, pwm = 1'b0, dir = 1'b0, hot = 1'b0, lim = 1'b0;
    logic [3:0] sh = 4'h0; // {bb, gb, ba, ga}
    logic opn = 1'b0, opp = 1'b0, fwp = 1'b0, low = 1'b0, slp = 1'b0;
    logic sel_n, sclk, sdi, sdo, oe_n, en, bdir, bpwm, probe, beacon;
    logic [7:0] setup = 8'h00;
    logic [2:0] last = 3'h1;
    logic [31:0] seed = 32'd64;
    logic [31:0] r;
    int error_cnt = 0;
    int n_compared = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    bsdc_top #(.VERSION(VER)) i_dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .select_n_in(sel_n), .sclk_in(sclk), .sdi_in(sdi),
        .bridge_off_pin_in(off), .pwm_in(pwm), .dir_in(dir),
        .overheat_flag_in(hot), .current_limit_flag_in(lim),
        .ground_short_a_in(sh[0]), .battery_short_a_in(sh[1]),
        .ground_short_b_in(sh[2]), .battery_short_b_in(sh[3]),
        .open_off_in(opn), .open_pulse_in(opp),
        .freewheel_pulse_in(fwp), .supply_low_in(low), .sleep_in(slp),
        .sdo_out(sdo), .sdo_oe_n_out(oe_n), .bridge_enable_out(en),
        .bridge_dir_out(bdir), .bridge_pwm_out(bpwm),
        .load_probe_on_out(probe), .fault_beacon_out(beacon)
    );

    bsdc_host i_host (
        .clk_sys_in(clk_sys_in), .sdo_in(sdo), .select_n_out(sel_n),
        .sclk_out(sclk), .sdi_out(sdi)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // both shorts on one output show as ground only
    function automatic logic [3:0] sc(logic [3:0] m);
        return ~{m[3] & ~m[2], m[2], m[1] & ~m[0], m[0]};
    endfunction

    function automatic logic [7:0] fw(logic [3:0] code, logic cl_on = 0);
        return {~off, ~hot, 1'b0, ~cl_on, code};
    endfunction

    function automatic logic [7:0] answer(logic [7:0] fword);
        case (last)
            3'h1: return {4'h2, VER};
            3'h3, 3'h7: return setup;
            default: return fword;
        endcase
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] cmd, input logic [7:0] fword,
                        input logic lead = 1'b1, input logic bcn = 1'b0);
        logic old;
        i_host.frame(cmd, lead);
        check({7'h0, oe_n}, 8'h01);
        check({7'h0, i_host.flag}, {7'h0, lead | bcn});
        check(i_host.resp, answer(fword));
        last = cmd[7:5];
        if (cmd[7:6] == 2'b11) begin
            old = setup[3];
            setup = cmd;
            if (off | pwm | dir)
                setup[3] = old;
        end
    endtask

    task automatic pulse_sh(input logic [3:0] m);
        sh <= m;
        tick(4);
        sh <= 4'h0;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        tick(4);
        rst_n_in <= 1'b1;
        tick(6);
        xfer(8'h00, fw(4'hf), 1'b0, 1'b0);
        check({7'h0, beacon}, 8'h00);
        $display("reset and first answer done");
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            xfer({i[2:0], r[4:0]}, fw(4'hf));
        end
        xfer(8'he0, fw(4'hf));
        $display("command decode done");
        xfer(8'hee, fw(4'hf));
        tick(6);
        check({5'h0, en, bdir, bpwm}, 8'h06);
        xfer(8'hed, fw(4'hf));
        check({5'h0, en, bdir, bpwm}, 8'h05);
        xfer(8'he9, fw(4'hf));
        check({5'h0, en, bdir, bpwm}, 8'h01);
        pwm <= 1'b1;
        tick(8);
        pwm <= 1'b0;
        tick(8);
        setup[3] = 1'b0;
        check({5'h0, en, bdir, bpwm}, 8'h04);
        dir <= 1'b1;
        tick(8);
        xfer(8'hef, fw(4'hf));
        xfer(8'h60, fw(4'hf));
        dir <= 1'b0;
        tick(8);
        xfer(8'he0, fw(4'hf));
        $display("serial control done");
        xfer(8'h00, fw(4'hf));
        for (int m = 1; m < 16; m++) begin
            pulse_sh(m[3:0]);
            xfer(8'h80, fw(sc(m[3:0])));
        end
        xfer(8'h00, fw(4'hf));
        pulse_sh(4'h1);
        off <= 1'b1;
        tick(8);
        off <= 1'b0;
        tick(8);
        xfer(8'h00, fw(4'hf));
        pulse_sh(4'h4);
        slp <= 1'b1;
        tick(8);
        slp <= 1'b0;
        tick(8);
        xfer(8'h00, fw(4'hf));
        low <= 1'b1;
        tick(8);
        xfer(8'h00, fw(4'h3));
        low <= 1'b0;
        tick(8);
        xfer(8'h00, fw(4'hf));
        hot <= 1'b1;
        tick(8);
        xfer(8'h00, fw(4'hf));
        hot <= 1'b0;
        lim <= 1'b1;
        tick(8);
        lim <= 1'b0;
        tick(8);
        xfer(8'h00, fw(4'hf, 1'b1));
        xfer(8'h00, fw(4'hf, 1'b1));
        dir <= 1'b1;
        tick(8);
        xfer(8'h00, fw(4'hf));
        dir <= 1'b0;
        tick(8);
        $display("fault word done");
        for (int k = 0; k < 5; k++) begin
            opp <= 1'b1;
            tick(4);
            opp <= 1'b0;
            tick(4);
        end
        xfer(8'h00, fw(4'hc));
        for (int k = 0; k < 5; k++) begin
            fwp <= 1'b1;
            tick(4);
            fwp <= 1'b0;
            tick(4);
            if (k == 3)
                xfer(8'h00, fw(4'hc));
        end
        xfer(8'h00, fw(4'hf));
        off <= 1'b1;
        opn <= 1'b1;
        tick(8);
        xfer(8'h00, fw(4'hc), 1'b0, 1'b1);
        check({7'h0, probe}, 8'h01);
        xfer(8'hf0, fw(4'hc));
        xfer(8'h00, fw(4'hf));
        xfer(8'h00, fw(4'hf));
        check({7'h0, probe}, 8'h00);
        $display("open load done");
        tally_and_finish();
    end
endmodule // testbench
